/* hdl/bwd_wakeup_diag_error_regs.sv */
// Wake-up interrupt timing, sleep timer, counter corrections, probe ports and error flags.
// Assumes the low-power clock and the external wake request arrive as pins, asynchronous to i_clock.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module bwd_wakeup_diag_error_regs
	import bwd_pkg::*;
(
	input  wire logic                                   i_clock,
	input  wire logic                                   i_sys_rst,
	input  wire bwd_bus_req_type                        i_bus,
	output logic [31:0]                                 o_rdata,
	input  wire logic                                   i_low_power_clock,
	input  wire logic                                   i_ext_wake_req,
	input  wire logic                                   i_sleep_start,
	input  wire logic [31:0]                            i_sleep_duration_target,
	output logic                                        o_low_power_wakeup_interrupt,
	output logic                                        o_sleeping,
	output logic                                        o_counters_enable,
	output logic                                        o_apply_corrections,
	output logic [9:0]                                  o_fine_counter_phase_fix,
	output logic [26:0]                                 o_base_timer_fix,
	output logic [15:0]                                 o_zone_upper_bound,
	output logic [15:0]                                 o_zone_lower_bound,
	input  wire logic [PROBE_SOURCES*PROBE_WIDTH-1:0]   i_probe_sources,
	output logic [PROBE_PORTS*PROBE_WIDTH-1:0]          o_probe_bus,
	input  wire bwd_link_status_type                    i_link_status
);

	logic [31:0]         timing_reg;
	logic [31:0]         fine_corr_reg;
	logic [31:0]         base_corr_reg;
	logic [31:0]         diag_ctrl_reg;
	logic [31:0]         zone_upper_reg;
	logic [31:0]         zone_lower_reg;
	logic [31:0]         error_flags_reg;
	logic [31:0]         error_flags_next;
	logic [31:0]         rdata_reg;
	logic [31:0]         rdata_next;
	logic [2:0]          lp_sync_reg;
	logic [1:0]          ext_sync_reg;
	logic [31:0]         remaining_reg;
	logic [10:0]         ext_count_reg;
	logic                irq_reg;
	logic                infinite_reg;
	logic                counters_en_reg;
	logic                apply_reg;
	bwd_sleep_state_type state_reg;
	bwd_sleep_state_type state_next;

	wire logic        wr_timing    = i_bus.wr && (i_bus.addr == WAKEUP_IRQ_TIMING_OFFSET);
	wire logic        wr_fine      = i_bus.wr && (i_bus.addr == FINE_COUNTER_CORRECTION_OFFSET);
	wire logic        wr_base      = i_bus.wr && (i_bus.addr == BASE_TIME_CORRECTION_OFFSET);
	wire logic        wr_diag      = i_bus.wr && (i_bus.addr == DIAG_PORT_CONTROL_OFFSET);
	wire logic        wr_upper     = i_bus.wr && (i_bus.addr == DEBUG_ZONE_UPPER_OFFSET);
	wire logic        wr_lower     = i_bus.wr && (i_bus.addr == DEBUG_ZONE_LOWER_OFFSET);
	wire logic        wr_corr      = i_bus.wr && (i_bus.addr == SLEEP_CORRECTION_CTRL_OFFSET);
	wire logic        rd_errors    = i_bus.rd && (i_bus.addr == LINK_ERROR_FLAGS_OFFSET);

	wire logic [10:0] ext_delay    = timing_reg[EXT_DELAY_LSB +: 11];
	wire logic [10:0] set_lead     = timing_reg[SET_LEAD_LSB +: 11];
	wire logic [9:0]  clear_lead   = timing_reg[CLEAR_LEAD_LSB +: 10];
	wire logic        lp_tick      = lp_sync_reg[1] && !lp_sync_reg[2];
	wire logic        ext_wake     = ext_sync_reg[1];
	// Latched at sleep start so a retargeted duration cannot turn a sleep finite
	wire logic        infinite     = infinite_reg;
	wire logic        hit_set      = (remaining_reg == {21'h000000, set_lead});
	wire logic        hit_clear    = (remaining_reg == {22'h000000, clear_lead});

	// Register writes; reserved bits masked off on the way in
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			timing_reg     <= REG_RESET_VALUE;
			fine_corr_reg  <= REG_RESET_VALUE;
			base_corr_reg  <= REG_RESET_VALUE;
			diag_ctrl_reg  <= REG_RESET_VALUE;
			zone_upper_reg <= REG_RESET_VALUE;
			zone_lower_reg <= REG_RESET_VALUE;
		end else begin
			if (wr_timing)
				timing_reg <= i_bus.wdata & WAKEUP_IRQ_TIMING_MASK;
			if (wr_fine)
				fine_corr_reg <= i_bus.wdata & FINE_CORRECTION_MASK;
			if (wr_base)
				base_corr_reg <= i_bus.wdata & BASE_CORRECTION_MASK;
			if (wr_diag)
				diag_ctrl_reg <= i_bus.wdata & DIAG_CONTROL_MASK;
			if (wr_upper)
				zone_upper_reg <= i_bus.wdata & ZONE_BOUND_MASK;
			if (wr_lower)
				zone_lower_reg <= i_bus.wdata & ZONE_BOUND_MASK;
		end
	end

	assign o_fine_counter_phase_fix = fine_corr_reg[9:0];
	assign o_base_timer_fix         = base_corr_reg[26:0];
	assign o_zone_upper_bound       = zone_upper_reg[15:0];
	assign o_zone_lower_bound       = zone_lower_reg[15:0];

	// Probe ports: registered mux, forced to zero while disabled
	genvar port;
	generate
		for (port = 0; port < PROBE_PORTS; port++) begin : g_probe
			wire logic [7:0] ctrl_field = diag_ctrl_reg[port*PROBE_FIELD_W +: PROBE_FIELD_W];
			wire logic       port_en    = ctrl_field[PROBE_EN_BIT];
			wire logic [5:0] port_sel   = ctrl_field[PROBE_SEL_LSB +: 6];
			wire logic [7:0] picked     = i_probe_sources[port_sel*PROBE_WIDTH +: PROBE_WIDTH];
			logic [7:0]      bus_reg;
			always_ff @(posedge i_clock) begin
				if (i_sys_rst)
					bus_reg <= 8'h00;
				else
					bus_reg <= port_en ? picked : 8'h00;
			end
			assign o_probe_bus[port*PROBE_WIDTH +: PROBE_WIDTH] = bus_reg;
		end
	endgenerate

	// Error flags: sticky, cleared by reading; a new error in the read cycle stays set
	logic [5:0]       ones_count;
	always_comb begin
		ones_count = 6'h00;
		for (int ch = 0; ch < CHANNEL_COUNT; ch++)
			ones_count = ones_count + {5'h00, i_link_status.hop_channel_map[ch]};
	end

	wire logic err_format = i_link_status.format_checked && i_link_status.format_invalid;
	wire logic err_null   = i_link_status.tx_pointer_checked &&
	                        (i_link_status.tx_buffer_pointer == 14'h0000);
	wire logic err_radio  = i_link_status.radio_memory_late;
	wire logic err_chmap  = i_link_status.hop_start &&
	                        (ones_count != i_link_status.good_channel_count);

	always_comb begin
		error_flags_next = rd_errors ? REG_RESET_VALUE : error_flags_reg;
		if (err_format)
			error_flags_next[BAD_FORMAT_BIT] = 1'b1;
		if (err_null)
			error_flags_next[NULL_TX_POINTER_BIT] = 1'b1;
		if (err_radio)
			error_flags_next[RADIO_MEM_LATE_BIT] = 1'b1;
		if (err_chmap)
			error_flags_next[CHMAP_MISMATCH_BIT] = 1'b1;
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst)
			error_flags_reg <= REG_RESET_VALUE;
		else
			error_flags_reg <= error_flags_next;
	end

	// Pin synchronisers; the edge detector reads only the later stages
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			lp_sync_reg  <= 3'h0;
			ext_sync_reg <= 2'h0;
		end else begin
			lp_sync_reg  <= {lp_sync_reg[1:0], i_low_power_clock};
			ext_sync_reg <= {ext_sync_reg[0], i_ext_wake_req};
		end
	end

	// Sleep sequencing
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			SLP_AWAKE: begin
				if (i_sleep_start)
					state_next = SLP_COUNTING;
			end
			SLP_COUNTING: begin
				if (ext_wake)
					state_next = SLP_EXT_HOLD;
				else if (lp_tick && !infinite && remaining_reg <= 32'h00000001)
					state_next = SLP_WOKEN;
			end
			SLP_EXT_HOLD: begin
				if (ext_count_reg == 11'h000)
					state_next = SLP_WOKEN;
			end
			SLP_WOKEN: begin
				if (i_sleep_start)
					state_next = SLP_COUNTING;
			end
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			state_reg     <= SLP_AWAKE;
			remaining_reg <= REG_RESET_VALUE;
			ext_count_reg <= 11'h000;
			irq_reg       <= 1'b0;
			infinite_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (i_sleep_start && state_reg != SLP_COUNTING && state_reg != SLP_EXT_HOLD) begin
				remaining_reg <= i_sleep_duration_target;
				infinite_reg  <= (i_sleep_duration_target == REG_RESET_VALUE);
				irq_reg       <= 1'b0;
			end else if (state_reg == SLP_COUNTING) begin
				if (ext_wake) begin
					// Software keeps the delay at least clear lead plus one
					irq_reg       <= 1'b1;
					ext_count_reg <= ext_delay;
				end else begin
					if (lp_tick && !infinite)
						remaining_reg <= remaining_reg - 32'h00000001;
					if (!infinite && hit_clear)
						irq_reg <= 1'b0;
					else if (!infinite && hit_set)
						irq_reg <= 1'b1;
				end
			end else if (state_reg == SLP_EXT_HOLD) begin
				if (ext_count_reg == 11'h000)
					irq_reg <= 1'b0;
				else if (lp_tick)
					ext_count_reg <= ext_count_reg - 11'h001;
			end
		end
	end

	assign o_low_power_wakeup_interrupt = irq_reg;
	assign o_sleeping                   = (state_reg == SLP_COUNTING) || (state_reg == SLP_EXT_HOLD);

	// Correction apply: write-one action, only after a wake from sleep
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			counters_en_reg <= 1'b1;
			apply_reg       <= 1'b0;
		end else begin
			apply_reg <= wr_corr && i_bus.wdata[CORR_APPLY_BIT] && (state_reg == SLP_WOKEN);
			if (i_sleep_start)
				counters_en_reg <= 1'b0;
			else if (wr_corr && i_bus.wdata[CORR_APPLY_BIT] && state_reg == SLP_WOKEN)
				counters_en_reg <= 1'b1;
		end
	end

	assign o_counters_enable   = counters_en_reg;
	assign o_apply_corrections = apply_reg;

	// Read port: data in the cycle after the strobe only; unmapped reads zero
	always_comb begin
		rdata_next = REG_RESET_VALUE;
		if (i_bus.rd) begin
			unique case (i_bus.addr)
				WAKEUP_IRQ_TIMING_OFFSET:       rdata_next = timing_reg;
				FINE_COUNTER_CORRECTION_OFFSET: rdata_next = fine_corr_reg;
				BASE_TIME_CORRECTION_OFFSET:    rdata_next = base_corr_reg;
				DIAG_PORT_CONTROL_OFFSET:       rdata_next = diag_ctrl_reg;
				DIAG_PORT_STATUS_OFFSET:        rdata_next = o_probe_bus;
				DEBUG_ZONE_UPPER_OFFSET:        rdata_next = zone_upper_reg;
				DEBUG_ZONE_LOWER_OFFSET:        rdata_next = zone_lower_reg;
				LINK_ERROR_FLAGS_OFFSET:        rdata_next = error_flags_reg;
				default:                        rdata_next = REG_RESET_VALUE;
			endcase
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst)
			rdata_reg <= REG_RESET_VALUE;
		else
			rdata_reg <= rdata_next;
	end

	assign o_rdata = rdata_reg;

endmodule

`default_nettype wire

/* hdl/bwd_pkg.sv */
// Constants, field layouts and carrier types of the wake-up, diagnostic and error register bank.
// Assumes a single 40 MHz system clock and a plain strobe register port.
//
// What this block does
// - External wake: drop interrupt after delay cycles
// - Raise interrupt set-lead cycles before expiry
// - Drop interrupt clear-lead cycles before expiry
// - Hold 10-bit fine counter phase fix
// - Hold 27-bit base timer fix
// - Disabled probe port drives all zeros
// - Six-bit selector picks each port's signals
// - Selector matters only while port enabled
// - Status mirrors four probe buses, port0 lowest
// - Hold 16-bit zone upper bound
// - Hold 16-bit zone lower bound
// - Flag invalid control-structure format value
// - Flag null transmit buffer pointer
// - Flag late radio exchange-memory access
// - Flag channel map count mismatch at hop start
// - Sleep timer counts duration in low-power cycles
// - Writing one after a wake applies corrections, enables counters
package bwd_pkg;

	localparam logic [31:0] WAKEUP_IRQ_TIMING_OFFSET       = 32'h4000003C;
	localparam logic [31:0] FINE_COUNTER_CORRECTION_OFFSET = 32'h40000040;
	localparam logic [31:0] BASE_TIME_CORRECTION_OFFSET    = 32'h40000044;
	localparam logic [31:0] DIAG_PORT_CONTROL_OFFSET       = 32'h40000050;
	localparam logic [31:0] DIAG_PORT_STATUS_OFFSET        = 32'h40000054;
	localparam logic [31:0] DEBUG_ZONE_UPPER_OFFSET        = 32'h40000058;
	localparam logic [31:0] DEBUG_ZONE_LOWER_OFFSET        = 32'h4000005C;
	localparam logic [31:0] LINK_ERROR_FLAGS_OFFSET        = 32'h40000060;
	localparam logic [31:0] SLEEP_CORRECTION_CTRL_OFFSET   = 32'h4000006C;

	localparam logic [31:0] REG_RESET_VALUE = 32'h00000000;

	// Writable bit masks; everything else reads zero
	localparam logic [31:0] WAKEUP_IRQ_TIMING_MASK  = 32'hFFFFFFFF;
	localparam logic [31:0] FINE_CORRECTION_MASK    = 32'h000003FF;
	localparam logic [31:0] BASE_CORRECTION_MASK    = 32'h07FFFFFF;
	localparam logic [31:0] DIAG_CONTROL_MASK       = 32'hBFBFBFBF;
	localparam logic [31:0] ZONE_BOUND_MASK         = 32'h0000FFFF;

	localparam int EXT_DELAY_LSB   = 21;
	localparam int SET_LEAD_LSB    = 10;
	localparam int CLEAR_LEAD_LSB  = 0;
	localparam int PROBE_EN_BIT    = 7;
	localparam int PROBE_SEL_LSB   = 0;
	localparam int PROBE_FIELD_W   = 8;
	localparam int CORR_APPLY_BIT  = 0;

	localparam int BAD_FORMAT_BIT      = 11;
	localparam int NULL_TX_POINTER_BIT = 10;
	localparam int RADIO_MEM_LATE_BIT  = 8;
	localparam int CHMAP_MISMATCH_BIT  = 7;

	localparam int PROBE_PORTS     = 4;
	localparam int PROBE_WIDTH     = 8;
	localparam int PROBE_SOURCES   = 64;
	localparam int CHANNEL_COUNT   = 37;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} bwd_bus_req_type;

	typedef struct packed {
		logic                    format_checked;
		logic                    format_invalid;
		logic                    tx_pointer_checked;
		logic [13:0]             tx_buffer_pointer;
		logic                    radio_memory_late;
		logic                    hop_start;
		logic [CHANNEL_COUNT-1:0] hop_channel_map;
		logic [5:0]              good_channel_count;
	} bwd_link_status_type;

	typedef enum logic [3:0] {
		SLP_AWAKE    = 4'b0001,
		SLP_COUNTING = 4'b0010,
		SLP_EXT_HOLD = 4'b0100,
		SLP_WOKEN    = 4'b1000
	} bwd_sleep_state_type;

endpackage

/* verification/bwd_regs_properties.sv */
// Port-level checker of the wake-up, probe and error register bank.
// Bound to the bank; sees only its ports, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module bwd_regs_chk
	import bwd_pkg::*;
(
	input wire logic                                 i_clock,
	input wire logic                                 i_sys_rst,
	input wire bwd_bus_req_type                      i_bus,
	input wire logic [31:0]                          o_rdata,
	input wire logic                                 i_sleep_start,
	input wire logic                                 o_low_power_wakeup_interrupt,
	input wire logic                                 o_sleeping,
	input wire logic                                 o_counters_enable,
	input wire logic                                 o_apply_corrections,
	input wire logic [26:0]                          o_base_timer_fix,
	input wire logic [15:0]                          o_zone_upper_bound,
	input wire logic [PROBE_SOURCES*PROBE_WIDTH-1:0] i_probe_sources,
	input wire logic [PROBE_PORTS*PROBE_WIDTH-1:0]   o_probe_bus,
	input wire bwd_link_status_type                  i_link_status
);
	logic [31:0]         ctrl_q;
	logic [31:0]         probe_exp;
	logic [31:0]         ev;
	bwd_link_status_type ls;
	wire                 flags_rd = i_bus.rd && i_bus.addr == LINK_ERROR_FLAGS_OFFSET;
	assign ls = i_link_status;
	// Error events as they should land in the flag word
	assign ev = {20'h0, ls.format_checked && ls.format_invalid,
		ls.tx_pointer_checked && ls.tx_buffer_pointer == 14'h0, 1'b0, ls.radio_memory_late,
		ls.hop_start && $countones(ls.hop_channel_map) != ls.good_channel_count, 7'h0};
	always_ff @(posedge i_clock)
		if (i_sys_rst)
			ctrl_q <= 32'h0;
		else if (i_bus.wr && i_bus.addr == DIAG_PORT_CONTROL_OFFSET)
			ctrl_q <= i_bus.wdata;
	always_comb
		for (int k = 0; k < PROBE_PORTS; k++)
			probe_exp[8*k +: 8] = ctrl_q[8*k+7] ? i_probe_sources[8*ctrl_q[8*k +: 6] +: 8] : 8'h00;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	rdata_idle_a: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0)
		else $error("read data not zero outside a read");
	probe_mux_a: assert property (1'b1 |=> o_probe_bus == $past(probe_exp))
		else $error("probe bus differs from selection");
	status_mirror_a: assert property (i_bus.rd && i_bus.addr == DIAG_PORT_STATUS_OFFSET |=>
		o_rdata == $past(o_probe_bus)) else $error("status does not mirror probe bus");
	zone_upper_a: assert property (i_bus.wr && i_bus.addr == DEBUG_ZONE_UPPER_OFFSET |=>
		o_zone_upper_bound == $past(i_bus.wdata[15:0])) else $error("upper bound not stored");
	base_fix_a: assert property (i_bus.wr && i_bus.addr == BASE_TIME_CORRECTION_OFFSET |=>
		o_base_timer_fix == $past(i_bus.wdata[26:0])) else $error("base fix not stored");
	flag_set_a: assert property (ev != 0 ##1 !flags_rd ##1 flags_rd |=>
		(o_rdata & $past(ev, 3)) == $past(ev, 3)) else $error("error flag missing");
	flag_clear_a: assert property (flags_rd && ev == 0 ##1 ev == 0 ##1 flags_rd |=>
		o_rdata == 32'h0) else $error("error flags not cleared by read");
	apply_pulse_a: assert property (o_apply_corrections |-> o_counters_enable ##1 !o_apply_corrections)
		else $error("apply pulse malformed");
	sleep_entry_a: assert property (i_sleep_start && !o_sleeping |=> o_sleeping && !o_counters_enable)
		else $error("sleep not entered");
	irq_in_sleep_a: assert property ($rose(o_low_power_wakeup_interrupt) |-> o_sleeping)
		else $error("interrupt raised while awake");
	cover property ($rose(o_low_power_wakeup_interrupt));
	cover property (o_apply_corrections);
	cover property (flags_rd ##1 o_rdata != 32'h0);
endmodule
bind bwd_wakeup_diag_error_regs bwd_regs_chk bwd_regs_chk_inst (.i_clock, .i_sys_rst, .i_bus, .o_rdata,
	.i_sleep_start, .o_low_power_wakeup_interrupt, .o_sleeping, .o_counters_enable, .o_apply_corrections,
	.o_base_timer_fix, .o_zone_upper_bound, .i_probe_sources, .o_probe_bus, .i_link_status);
`default_nettype wire

/* verification/bwd_testbench.sv */
// Self-checking bench of the wake-up, probe and error register bank.
// Drives every port itself; low-power clock runs free at one eighth of i_clock.
`timescale 1ns/10ps
`default_nettype none
module testbench
	import bwd_pkg::*;
;
	logic                i_clock = 1'b0;
	logic                i_sys_rst = 1'b1;
	bwd_bus_req_type     i_bus = '0;
	logic [31:0]         o_rdata;
	logic                i_low_power_clock = 1'b0;
	logic                i_ext_wake_req = 1'b0;
	logic                i_sleep_start = 1'b0;
	logic [31:0]         i_sleep_duration_target = 32'h0;
	logic                irq, slp, cen, apl;
	logic [9:0]          fine;
	logic [26:0]         base;
	logic [15:0]         upr, lwr;
	logic [511:0]        i_probe_sources;
	logic [31:0]         o_probe_bus;
	bwd_link_status_type i_link_status = '0;
	int                  n_mismatch = 0, cmp_count = 0, lp_cnt = 0, lp_div = 0;

	bwd_wakeup_diag_error_regs bwd_wakeup_diag_error_regs_inst (.i_clock, .i_sys_rst, .i_bus, .o_rdata,
		.i_low_power_clock, .i_ext_wake_req, .i_sleep_start, .i_sleep_duration_target,
		.o_low_power_wakeup_interrupt(irq), .o_sleeping(slp), .o_counters_enable(cen),
		.o_apply_corrections(apl), .o_fine_counter_phase_fix(fine), .o_base_timer_fix(base),
		.o_zone_upper_bound(upr), .o_zone_lower_bound(lwr), .i_probe_sources, .o_probe_bus, .i_link_status);

	initial begin
		forever #12.5 i_clock = ~i_clock;
	end
	// Ticks are counted where they are driven, ahead of the pin synchroniser
	always @(posedge i_clock) begin
		lp_div <= (lp_div + 1) % 8;
		i_low_power_clock <= lp_div == 7 || lp_div < 3;
		if (lp_div == 7)
			lp_cnt <= lp_cnt + 1;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_clock);
		i_bus <= '0;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		@(posedge i_clock);
		i_bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge i_clock);
		i_bus <= '0;
		#1 chk(o_rdata, exp);
	endtask
	task automatic align(input int ph);
		@(posedge i_clock);
		while (lp_div != ph)
			@(posedge i_clock);
	endtask
	task automatic give_verdict();
		$display("mismatches=%0d comparisons=%0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		#(4000 * 25);
		n_mismatch++;
		give_verdict();
	end

	initial begin
		logic [31:0]         offs [8];
		logic [31:0]         ex [2][8];
		logic [31:0]         pat [2];
		logic [31:0]         evx [5];
		bwd_link_status_type e;
		int                  b;
		offs = '{32'h4000003C, 32'h40000040, 32'h40000044, 32'h40000050,
			32'h40000054, 32'h40000058, 32'h4000005C, 32'h40000060};
		pat = '{32'hFFFFFFFF, 32'h12345678};
		ex[0] = '{32'hFFFFFFFF, 32'h3FF, 32'h07FFFFFF, 32'hBFBFBFBF, 32'h9A9A9A9A, 32'hFFFF, 32'hFFFF, 32'h0};
		ex[1] = '{32'h12345678, 32'h278, 32'h02345678, 32'h12341638, 32'h0, 32'h5678, 32'h5678, 32'h0};
		evx = '{32'h800, 32'h400, 32'h100, 32'h080, 32'h0};
		for (int n = 0; n < 64; n++)
			i_probe_sources[8*n +: 8] = 8'(n) ^ 8'hA5;
		repeat (4) @(posedge i_clock);
		i_sys_rst <= 1'b0;
		chk({31'h0, cen}, 32'h1);
		for (int i = 0; i < 8; i++)
			rd(offs[i], 32'h0);
		rd(32'h40000048, 32'h0);
		for (int p = 0; p < 2; p++)
			for (int i = 0; i < 8; i++) begin
				wr(offs[i], pat[p]);
				rd(offs[i], ex[p][i]);
			end
		chk({fine, base[21:0]}, {10'h278, 22'h345678});
		chk({upr, lwr}, 32'h56785678);
		// Port 2 disabled but selecting; port 0 at the upper select bound, port 3 on source 42
		wr(32'h40000050, 32'hAA1185BF);
		rd(32'h40000054, 32'h8F00A09A);
		chk(o_probe_bus, 32'h8F00A09A);
		i_probe_sources[42*8 +: 8] <= 8'h3C;
		rd(32'h40000054, 32'h3C00A09A);
		for (int k = 0; k < 5; k++) begin
			e = '0;
			case (k)
				0: e.format_invalid = 1'b1;
				1: e.tx_pointer_checked = 1'b1;
				2: e.radio_memory_late = 1'b1;
				3: begin
					e.hop_start = 1'b1;
					e.hop_channel_map = 37'h1000000000;
				end
				default: begin
					e.tx_pointer_checked = 1'b1;
					e.tx_buffer_pointer = 14'h1;
					e.hop_start = 1'b1;
					e.hop_channel_map = {37{1'b1}};
					e.good_channel_count = 6'd37;
				end
			endcase
			e.format_checked = k != 4;
			@(posedge i_clock);
			i_link_status <= e;
			@(posedge i_clock);
			i_link_status <= '0;
			rd(32'h40000060, evx[k]);
			rd(32'h40000060, 32'h0);
		end
		wr(32'h4000003C, 32'h00601001);
		align(3);
		i_sleep_start <= 1'b1;
		i_sleep_duration_target <= 32'd10;
		b = lp_cnt;
		@(posedge i_clock);
		i_sleep_start <= 1'b0;
		for (int i = 0; i < 200 && irq !== 1'b1; i++) @(posedge i_clock);
		chk({cen, slp, 30'(lp_cnt - b)}, {2'b01, 30'd6});
		for (int i = 0; i < 200 && irq !== 1'b0; i++) @(posedge i_clock);
		chk(lp_cnt - b, 32'd9);
		for (int i = 0; i < 200 && slp !== 1'b0; i++) @(posedge i_clock);
		chk(lp_cnt - b, 32'd10);
		wr(32'h4000006C, 32'h0);
		#1 chk({apl, cen}, 2'b00);
		wr(32'h4000006C, 32'h1);
		#1 chk({apl, cen}, 2'b11);
		align(3);
		i_sleep_start <= 1'b1;
		i_sleep_duration_target <= 32'd0;
		@(posedge i_clock);
		i_sleep_start <= 1'b0;
		repeat (40) @(posedge i_clock);
		chk({irq, slp}, 2'b01);
		align(2);
		i_ext_wake_req <= 1'b1;
		b = lp_cnt;
		for (int i = 0; i < 20 && irq !== 1'b1; i++) @(posedge i_clock);
		i_ext_wake_req <= 1'b0;
		for (int i = 0; i < 200 && irq !== 1'b0; i++) @(posedge i_clock);
		chk({slp, 31'(lp_cnt - b)}, 32'd3);
		give_verdict();
	end
endmodule
`default_nettype wire
